// *** verilog/qtcp_map.vh ***
`ifndef QTCP_MAP_VH
`define QTCP_MAP_VH

// register byte offsets on the bus
`define QTCP_OFF_CTRL      8'h00
`define QTCP_OFF_DATA      8'h04
`define QTCP_OFF_VALID     8'h08

// control register field positions
`define QTCP_CTRL_BANK_BIT 7
`define QTCP_CTRL_LH_BIT   4
`define QTCP_CTRL_IDX_MSB  3
`define QTCP_CTRL_IDX_LSB  0

// list entry field positions
`define QTCP_LIST_DIFFERENTIAL_FLAG_BIT 4
`define QTCP_LIST_CH_MSB   3

// storage sizes
`define QTCP_ENTRIES       16
`define QTCP_IDX_W         4
`define QTCP_THR_W         10
`define QTCP_LIST_W        5
`define QTCP_PORT_W        16

// channel code limits
`define QTCP_CH_MAX_BOTH   4'h7
`define QTCP_CH_MAX_SE     4'hC

// reset values
`define QTCP_RST_CTRL      16'h0000
`define QTCP_RST_ENTRY     16'h0000

// bus responses
`define QTCP_RESP_OKAY     2'h0
`define QTCP_RESP_DECERR   2'h3

`endif

// *** verilog/qtcp_bank.v ***
`timescale 1ns/10ps
`default_nettype none
`include "qtcp_map.vh"

module qtcp_bank #(
    parameter WIDTH   = 10,
    parameter ENTRIES = 16,
    parameter IDX_W   = 4
) (
    input  wire                     clock,
    input  wire                     arst_n,
    input  wire                     wr_en,
    input  wire [IDX_W-1:0]         idx,
    input  wire [WIDTH-1:0]         wr_data,
    output wire [WIDTH-1:0]         rd_data,
    output wire [WIDTH*ENTRIES-1:0] all_flat
);

    // reset word cut to the entry width
    localparam [15:0] RST_WORD = `QTCP_RST_ENTRY;

    reg [WIDTH-1:0] mem_q [0:ENTRIES-1];
    integer         i;
    genvar          g;

    // entry storage, cleared at reset
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < ENTRIES; i = i + 1) begin
                mem_q[i] <= RST_WORD[WIDTH-1:0];
            end
        end else if (wr_en) begin
            mem_q[idx] <= wr_data;
        end
    end

    // selected entry and flat view for the comparison engine
    assign rd_data = mem_q[idx];
    generate
        for (g = 0; g < ENTRIES; g = g + 1) begin : g_flat
            assign all_flat[g*WIDTH +: WIDTH] = mem_q[g];
        end
    endgenerate

endmodule

`default_nettype wire

// *** verilog/qtcp_config_port.v ***
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "qtcp_map.vh"

// Summary of operation
// - bank select zero reaches threshold banks
// - bank select one reaches list bank
// - low/high zero picks indexed low threshold
// - low/high one picks indexed high threshold
// - thresholds keep 10 bits, upper read zero
// - selects plus index address every data access
// - list bit 4 marks channel differential
// - index advances after each data access
// - each bank holds sixteen indexed entries
// - codes 8 to 12 single-ended only
module qtcp_config_port #(
    parameter ADDR_W  = 8,
    parameter ENTRIES = 16
) (
    input  wire                   clock,
    input  wire                   arst_n,
    input  wire [ADDR_W-1:0]      s_axi_awaddr,
    input  wire                   s_axi_awvalid,
    output wire                   s_axi_awready,
    input  wire [31:0]            s_axi_wdata,
    input  wire [3:0]             s_axi_wstrb,
    input  wire                   s_axi_wvalid,
    output wire                   s_axi_wready,
    output wire [1:0]             s_axi_bresp,
    output wire                   s_axi_bvalid,
    input  wire                   s_axi_bready,
    input  wire [ADDR_W-1:0]      s_axi_araddr,
    input  wire                   s_axi_arvalid,
    output wire                   s_axi_arready,
    output wire [31:0]            s_axi_rdata,
    output wire [1:0]             s_axi_rresp,
    output wire                   s_axi_rvalid,
    input  wire                   s_axi_rready,
    output wire [10*ENTRIES-1:0]  low_thr_flat,
    output wire [10*ENTRIES-1:0]  high_thr_flat,
    output wire [5*ENTRIES-1:0]   list_flat,
    output reg  [ENTRIES-1:0]     list_valid_q
);

    reg  [ADDR_W-1:0]          aw_addr_q;
    reg                        aw_ok_q;
    reg  [15:0]                wdata_q;
    reg  [1:0]                 wstrb_q;
    reg                        w_ok_q;
    reg                        bvalid_q;
    reg  [1:0]                 bresp_q;
    reg                        rvalid_q;
    reg  [1:0]                 rresp_q;
    reg  [31:0]                rdata_q;
    reg                        bank_sel_q;
    reg                        lh_sel_q;
    reg  [`QTCP_IDX_W-1:0]     idx_q;
    wire                       wr_go;
    wire                       rd_go;
    wire                       wr_ctrl;
    wire                       wr_data;
    wire                       rd_ctrl;
    wire                       rd_data;
    wire                       rd_valid;
    wire [15:0]                ctrl_view;
    reg  [15:0]                data_view;
    wire [15:0]                strb_mask;
    wire [15:0]                merged;
    wire [`QTCP_THR_W-1:0]     low_rd;
    wire [`QTCP_THR_W-1:0]     high_rd;
    wire [`QTCP_LIST_W-1:0]    list_rd;
    wire                       low_we;
    wire                       high_we;
    wire                       list_we;
    reg  [ENTRIES-1:0]         valid_d;
    integer                    k;

    // channel code legal for its mode
    function chan_ok;
        input       differential_flag;
        input [3:0] ch;
        begin
            chan_ok = (ch <= `QTCP_CH_MAX_BOTH) || (!differential_flag && ch <= `QTCP_CH_MAX_SE);
        end
    endfunction

    // word-aligned address match
    function addr_is;
        input [ADDR_W-1:0] addr;
        input [7:0]        off;
        begin
            addr_is = ({addr[ADDR_W-1:2], 2'b00} == off[ADDR_W-1:0]);
        end
    endfunction

    // bus handshakes; reads wait while a write executes
    assign s_axi_awready = !aw_ok_q;
    assign s_axi_wready  = !w_ok_q;
    assign wr_go         = aw_ok_q && w_ok_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q && !wr_go;
    assign rd_go         = s_axi_arvalid && s_axi_arready;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // decode
    assign wr_ctrl  = wr_go && addr_is(aw_addr_q, `QTCP_OFF_CTRL);
    assign wr_data  = wr_go && addr_is(aw_addr_q, `QTCP_OFF_DATA);
    assign rd_ctrl  = addr_is(s_axi_araddr, `QTCP_OFF_CTRL);
    assign rd_data  = addr_is(s_axi_araddr, `QTCP_OFF_DATA);
    assign rd_valid = addr_is(s_axi_araddr, `QTCP_OFF_VALID);

    // control register image
    assign ctrl_view = {8'h00, bank_sel_q, 2'b00, lh_sel_q, idx_q};

    // data port view of the addressed entry
    always @* begin
        data_view = 16'h0000;
        if (bank_sel_q) begin
            data_view = {11'h000, list_rd};
        end else if (lh_sel_q) begin
            data_view = {6'h00, high_rd};
        end else begin
            data_view = {6'h00, low_rd};
        end
    end

    // byte-strobe merge into the current view
    assign strb_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign merged    = (data_view & ~strb_mask) | (wdata_q & strb_mask);

    // bank write enables from the selects
    assign low_we  = wr_data && !bank_sel_q && !lh_sel_q;
    assign high_we = wr_data && !bank_sel_q && lh_sel_q;
    assign list_we = wr_data && bank_sel_q;

    // write address and data capture, response
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            aw_addr_q <= {ADDR_W{1'b0}};
            aw_ok_q   <= 1'b0;
            wdata_q   <= 16'h0000;
            wstrb_q   <= 2'b00;
            w_ok_q    <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `QTCP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= s_axi_awaddr;
                aw_ok_q   <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata[15:0];
                wstrb_q <= s_axi_wstrb[1:0];
                w_ok_q  <= 1'b1;
            end
            if (wr_go) begin
                aw_ok_q  <= 1'b0;
                w_ok_q   <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= (wr_ctrl || wr_data || addr_is(aw_addr_q, `QTCP_OFF_VALID)) ?
                            `QTCP_RESP_OKAY : `QTCP_RESP_DECERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read response
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_q <= 1'b0;
            rresp_q  <= `QTCP_RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q  <= (rd_ctrl || rd_data || rd_valid) ? `QTCP_RESP_OKAY : `QTCP_RESP_DECERR;
            if (rd_ctrl) begin
                rdata_q <= {16'h0000, ctrl_view};
            end else if (rd_data) begin
                rdata_q <= {16'h0000, data_view};
            end else if (rd_valid) begin
                rdata_q <= {{(32-ENTRIES){1'b0}}, list_valid_q};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // control fields; data access steps the index
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bank_sel_q <= 1'b0;
            lh_sel_q   <= 1'b0;
            idx_q      <= {`QTCP_IDX_W{1'b0}};
        end else if (wr_ctrl) begin
            if (wstrb_q[0]) begin
                bank_sel_q <= wdata_q[`QTCP_CTRL_BANK_BIT];
                lh_sel_q   <= wdata_q[`QTCP_CTRL_LH_BIT];
                idx_q      <= wdata_q[`QTCP_CTRL_IDX_MSB:`QTCP_CTRL_IDX_LSB];
            end
        end else if (wr_data || (rd_go && rd_data)) begin
            idx_q <= idx_q + 4'h1;
        end
    end

    // per-entry channel legality for the comparison engine
    always @* begin
        valid_d = {ENTRIES{1'b0}};
        for (k = 0; k < ENTRIES; k = k + 1) begin
            valid_d[k] = chan_ok(list_flat[k*5 + `QTCP_LIST_DIFFERENTIAL_FLAG_BIT],
                                 list_flat[k*5 +: 4]);
        end
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            list_valid_q <= {ENTRIES{1'b1}};
        end else begin
            list_valid_q <= valid_d;
        end
    end

    // three sixteen-entry banks
    qtcp_bank #(
        .WIDTH   (`QTCP_THR_W),
        .ENTRIES (ENTRIES),
        .IDX_W   (`QTCP_IDX_W)
    ) u_low (
        .clock    (clock),
        .arst_n   (arst_n),
        .wr_en    (low_we),
        .idx      (idx_q),
        .wr_data  (merged[`QTCP_THR_W-1:0]),
        .rd_data  (low_rd),
        .all_flat (low_thr_flat)
    );

    qtcp_bank #(
        .WIDTH   (`QTCP_THR_W),
        .ENTRIES (ENTRIES),
        .IDX_W   (`QTCP_IDX_W)
    ) u_high (
        .clock    (clock),
        .arst_n   (arst_n),
        .wr_en    (high_we),
        .idx      (idx_q),
        .wr_data  (merged[`QTCP_THR_W-1:0]),
        .rd_data  (high_rd),
        .all_flat (high_thr_flat)
    );

    qtcp_bank #(
        .WIDTH   (`QTCP_LIST_W),
        .ENTRIES (ENTRIES),
        .IDX_W   (`QTCP_IDX_W)
    ) u_list (
        .clock    (clock),
        .arst_n   (arst_n),
        .wr_en    (list_we),
        .idx      (idx_q),
        .wr_data  (merged[`QTCP_LIST_W-1:0]),
        .rd_data  (list_rd),
        .all_flat (list_flat)
    );

endmodule

`default_nettype wire

// *** verif/qtcp_config_port_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module qtcp_port_chk #(
    parameter ENTRIES = 16
) (
    input wire logic                 clock,
    input wire logic                 arst_n,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_wready,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_arready,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic [10*ENTRIES-1:0] low_thr_flat,
    input wire logic [10*ENTRIES-1:0] high_thr_flat,
    input wire logic [5*ENTRIES-1:0] list_flat,
    input wire logic [ENTRIES-1:0]   list_valid_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    // channel code legal for its mode
    function automatic logic ok(input logic [4:0] e);
        return e[3:0] <= 4'h7 || (!e[4] && e[3:0] <= 4'hC);
    endfunction

    // write executing, read answer waiting
    sequence wr_exec;
        !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    endsequence
    sequence rd_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence

    wr_answer_a: assert property (wr_exec |=> s_axi_bvalid)
        else $error("no write response after execute");
    entry_write_a: assert property ($changed(low_thr_flat) || $changed(high_thr_flat)
        || $changed(list_flat) |-> s_axi_bvalid && !$past(s_axi_awready))
        else $error("entry changed without a write");
    one_bank_a: assert property ($changed(low_thr_flat) + $changed(high_thr_flat)
        + $changed(list_flat) <= 1) else $error("several banks written at once");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("read upper bits not zero");
    list_ok0_a: assert property (list_valid_q[0] == ok($past(list_flat[4:0])))
        else $error("entry 0 validity wrong");
    list_ok15_a: assert property (list_valid_q[ENTRIES-1] == ok($past(list_flat[5*ENTRIES-1 -: 5])))
        else $error("last entry validity wrong");
    rd_hold_a: assert property (rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answering");
endmodule

bind qtcp_config_port qtcp_port_chk #(.ENTRIES(ENTRIES)) u_chk (
    .clock(clock), .arst_n(arst_n), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .low_thr_flat(low_thr_flat),
    .high_thr_flat(high_thr_flat), .list_flat(list_flat), .list_valid_q(list_valid_q));
`default_nettype wire

// *** verif/tb_quick_trip_config_port.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_quick_trip_config_port;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    wire         awready, wready, bvalid, arready, rvalid;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [159:0] lo, hi;
    wire [79:0]  ls;
    wire [15:0]  lv;
    logic [15:0] mm [0:2][0:15];
    logic        bank = 1'b0, lh = 1'b0;
    logic [3:0]  idx = 4'h0;
    logic [15:0] c;
    int          error_cnt = 0, cmp_count = 0, seed = 68, m, i;

    always #5 clock = ~clock;

    qtcp_config_port DUT (
        .clock(clock), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .low_thr_flat(lo),
        .high_thr_flat(hi), .list_flat(ls), .list_valid_q(lv));

    // compare and count
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task wrap_up;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // model: legal channel code for its mode
    function logic okf(input logic [15:0] e);
        return e[3:0] <= 4'h7 || (!e[4] && e[3:0] <= 4'hC);
    endfunction

    // bus write, then model update and entry compare
    task wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        int n, k;
        logic [15:0] v;
        @(posedge clock);
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        if (bvalid !== 1'b1) begin
            error_cnt++;
            wrap_up;
        end
        if (a == 8'h00 && s[0]) {bank, lh, idx} = {d[7], d[4], d[3:0]};
        k = bank ? 2 : lh;
        v = mm[k][idx];
        if (s[0]) v[7:0] = d[7:0];
        if (s[1]) v[15:8] = d[15:8];
        if (a == 8'h04) begin
            mm[k][idx] = v & (bank ? 16'h001F : 16'h03FF);
            idx++;
        end
        chk(bresp, a > 8'h08 ? 32'h3 : 32'h0);
        for (n = 0; n < 16; n++) begin
            chk(lo[10*n+:10], mm[0][n]);
            chk(hi[10*n+:10], mm[1][n]);
            chk(ls[5*n+:5], mm[2][n]);
        end
        // validity flags lag the list by one edge; look once settled
        #1;
        for (n = 0; n < 16; n++) begin
            chk(lv[n], okf(mm[2][n]));
        end
    endtask

    // bus read compared with the model
    task rd(input logic [7:0] a);
        int n;
        logic [31:0] e;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        if (rvalid !== 1'b1) begin
            error_cnt++;
            wrap_up;
        end
        e = 32'h0;
        if (a == 8'h00) e = {bank, 2'b00, lh, idx};
        if (a == 8'h08) for (n = 0; n < 16; n++) e[n] = okf(mm[2][n]);
        if (a == 8'h04) begin
            e = mm[bank ? 2 : lh][idx];
            idx++;
        end
        chk(rdata, e);
        chk(rresp, a > 8'h08 ? 32'h3 : 32'h0);
    endtask

    // main sequence
    initial begin
        for (i = 0; i < 48; i++) mm[i / 16][i % 16] = 16'h0000;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        for (m = 0; m < 3; m++) begin
            c = (m == 2) ? 16'h0080 : (m == 1) ? 16'h0010 : 16'h0000;
            wr(8'h00, c, 4'h1);
            for (i = 0; i < 17; i++) rd(8'h04);
            wr(8'h00, c | 16'($random(seed) & 15), 4'h1);
            for (i = 0; i < 16; i++) wr(8'h04, 16'($random(seed)), 4'h3);
            for (i = 0; i < 16; i++) rd(8'h04);
            rd(8'h00);
        end
        wr(8'h00, 16'h0090, 4'h1);
        for (i = 0; i < 32; i++) begin
            wr(8'h04, 16'(i), 4'h3);
            if (i % 16 == 15) rd(8'h08);
        end
        wr(8'h00, 16'h0013, 4'h1);
        wr(8'h04, 16'hABCD, 4'h2);
        wr(8'h04, 16'h1234, 4'h0);
        wr(8'h00, 16'h0003, 4'h2);
        wr(8'h00, 16'h0013, 4'h1);
        rd(8'h04);
        rd(8'h04);
        wr(8'h00, 16'hFFFF, 4'h1);
        rd(8'h00);
        wr(8'h08, 16'hFFFF, 4'h3);
        rd(8'h08);
        wr(8'h0C, 16'h0001, 4'hF);
        rd(8'h0C);
        wrap_up;
    end
endmodule
`default_nettype wire
